// >>> rtl/tsbuf_defines.svh
// Constants for the two-bank time stamp capture buffer
`ifndef TSBUF_DEFINES_SVH
`define TSBUF_DEFINES_SVH
// ----------------------------------------
// Command configuration field positions
// ----------------------------------------
`define TSBUF_CFG_CNT_CLR_BIT 7
`define TSBUF_CFG_FLAG_CLR_BIT 4
`define TSBUF_CLEAR_CMD 8'h90
// ----------------------------------------
// Bank addresses and reset values
// ----------------------------------------
`define TSBUF_BANK_FIRST 1'h0
`define TSBUF_BANK_SECOND 1'h1
`define TSBUF_EMPTY_RST 1'h1
`define TSBUF_FULL_RST 1'h0
`define TSBUF_OVW_RST 1'h0
`define TSBUF_CNT_W 6
`define TSBUF_CNT_RST 6'h00
`define TSBUF_CNT_ONE 6'h01
// ----------------------------------------
// Host spacing between trigger commands
// ----------------------------------------
`define TSBUF_TRIG_GAP_MS 5
`endif

// >>> rtl/tsbuf_pkg.sv
// Types shared by the time stamp buffer modules
package tsbuf_pkg;
	typedef enum logic {TSBUF_MODE_INHIBIT, TSBUF_MODE_OVERWRITE} tsbuf_mode_t;
	typedef struct packed {
		logic empty;
		logic full;
		logic ovw;
	} tsbuf_status_t;
endpackage

// >>> rtl/tsbuf_mem_if.sv
// Write and read port bundle between buffer control and bank storage
`timescale 1ns/100ps
interface tsbuf_mem_if #(parameter int DW = 64, parameter int AW = 1);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic rd_en;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// >>> rtl/tsbuf_mem.sv
// Bank storage for captured time stamps with registered read data
`timescale 1ns/100ps
module tsbuf_mem #(
	parameter int DW = 64,
	parameter int DEPTH = 2
) (
	input wire logic clk,          // Block clock
	input wire logic rst_n,        // Synchronous reset, active low
	tsbuf_mem_if.mem port_if       // Write and read port
);
	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] bank;
		logic [DW-1:0] rd;
	} tsbuf_mem_state_t;

	tsbuf_mem_state_t st_ff;
	tsbuf_mem_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (port_if.wr_en) begin
			nxt_st.bank[port_if.wr_addr] = port_if.wr_data;
		end
		if (port_if.rd_en) begin
			nxt_st.rd = st_ff.bank[port_if.rd_addr];
		end
	end

	// Bank contents are left undefined by reset; only the read register is cleared
	always_ff @(posedge clk) begin
		st_ff <= nxt_st;
		if (!rst_n) begin
			st_ff.rd <= '0;
		end
	end

	assign port_if.rd_data = st_ff.rd;
endmodule // tsbuf_mem

// >>> rtl/tsbuf_top.sv
// Two-bank time stamp capture buffer with status flags and event counters
`timescale 1ns/100ps
`include "tsbuf_defines.svh"
module tsbuf_top #(
	parameter int DW = 64,
	parameter int NIN = 3
) (
	input wire logic REF_CLK,                      // 25 MHz block clock
	input wire logic RST_N,                        // Synchronous reset, active low
	input wire logic CAP_VALID,                    // One-cycle capture strobe
	input wire logic [DW-1:0] CAP_DATA,            // Time stamp to store
	input wire logic [NIN-1:0] CAP_SRC,            // One-hot input that caused the capture
	input wire tsbuf_pkg::tsbuf_mode_t OVW_MODE,   // Overwrite or inhibit when full
	input wire logic [7:0] CMD_CFG,                // Command configuration register value
	input wire logic CMD_TRG_WR,                   // Pulse: host wrote the trigger register
	input wire logic RD_REQ,                       // Pulse: host reads a bank
	input wire logic RD_BANK,                      // 0 selects bank 6, 1 bank 7
	output logic [DW-1:0] RD_DATA,                 // Bank read data
	output logic RD_VALID,                         // Pulse: RD_DATA holds the answer
	output logic BUF_EMPTY,                        // Buffer empty flag
	output logic BUF_FULL,                         // Buffer full flag
	output logic BUF_OVW,                          // Buffer overwrite flag
	output logic IRQ_NOT_EMPTY,                    // Pulse: buffer became not empty
	output logic IRQ_FULL,                         // Pulse: buffer became full
	output logic IRQ_OVW,                          // Pulse: capture arrived while full
	output logic [NIN-1:0][5:0] EVT_COUNT          // Per-input event counters
);
	import tsbuf_pkg::*;

	typedef struct packed {
		tsbuf_status_t stat;
		logic irq_ne;
		logic irq_full;
		logic irq_ovw;
		logic rd_valid;
		logic [NIN-1:0][`TSBUF_CNT_W-1:0] cnt;
	} tsbuf_state_t;

	tsbuf_state_t st_ff;
	tsbuf_state_t nxt_st;
	tsbuf_status_t base;
	logic clr_flags;
	logic clr_cnt;

	tsbuf_mem_if #(.DW(DW), .AW(1)) mem_if ();

	tsbuf_mem #(.DW(DW), .DEPTH(2)) u_mem (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.port_if(mem_if)
	);

	function automatic logic cfg_bit(input logic trg, input logic [7:0] cfg, input int pos);
		cfg_bit = trg & cfg[pos];
	endfunction

	// ----------------------------------------
	// Command trigger decode
	// ----------------------------------------
	assign clr_flags = cfg_bit(CMD_TRG_WR, CMD_CFG, `TSBUF_CFG_FLAG_CLR_BIT);
	assign clr_cnt = cfg_bit(CMD_TRG_WR, CMD_CFG, `TSBUF_CFG_CNT_CLR_BIT);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// A capture in the same cycle as a clear is applied after the clear, so it is never lost
	always_comb begin
		nxt_st = st_ff;
		mem_if.wr_en = 1'b0;
		mem_if.wr_addr = `TSBUF_BANK_FIRST;
		mem_if.wr_data = CAP_DATA;
		base = st_ff.stat;
		if (clr_flags) begin
			base = '{empty: `TSBUF_EMPTY_RST, full: `TSBUF_FULL_RST, ovw: `TSBUF_OVW_RST};
		end
		nxt_st.stat = base;
		// Overwrite request repeats on every capture while full, even once the flag is set
		nxt_st.irq_ovw = 1'b0;
		if (CAP_VALID) begin
			if (base.empty) begin
				mem_if.wr_en = 1'b1;
				mem_if.wr_addr = `TSBUF_BANK_FIRST;
				nxt_st.stat.empty = 1'b0;
			end else if (!base.full) begin
				mem_if.wr_en = 1'b1;
				mem_if.wr_addr = `TSBUF_BANK_SECOND;
				nxt_st.stat.full = 1'b1;
			end else begin
				mem_if.wr_en = (OVW_MODE == TSBUF_MODE_OVERWRITE);
				mem_if.wr_addr = `TSBUF_BANK_SECOND;
				nxt_st.stat.ovw = 1'b1;
				nxt_st.irq_ovw = 1'b1;
			end
		end
		nxt_st.irq_ne = base.empty & ~nxt_st.stat.empty;
		nxt_st.irq_full = ~base.full & nxt_st.stat.full;
		for (int i = 0; i < NIN; i++) begin
			if (clr_cnt) begin
				nxt_st.cnt[i] = `TSBUF_CNT_RST;
			end
			if (CAP_VALID && CAP_SRC[i]) begin
				nxt_st.cnt[i] = nxt_st.cnt[i] + `TSBUF_CNT_ONE;
			end
		end
		// Reads only fetch data; flags are deliberately untouched here
		mem_if.rd_en = RD_REQ;
		mem_if.rd_addr = RD_BANK;
		nxt_st.rd_valid = RD_REQ;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			st_ff.stat <= '{empty: `TSBUF_EMPTY_RST, full: `TSBUF_FULL_RST, ovw: `TSBUF_OVW_RST};
			st_ff.irq_ne <= 1'b0;
			st_ff.irq_full <= 1'b0;
			st_ff.irq_ovw <= 1'b0;
			st_ff.rd_valid <= 1'b0;
			st_ff.cnt <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign BUF_EMPTY = st_ff.stat.empty;
	assign BUF_FULL = st_ff.stat.full;
	assign BUF_OVW = st_ff.stat.ovw;
	assign IRQ_NOT_EMPTY = st_ff.irq_ne;
	assign IRQ_FULL = st_ff.irq_full;
	assign IRQ_OVW = st_ff.irq_ovw;
	assign RD_VALID = st_ff.rd_valid;
	assign RD_DATA = mem_if.rd_data;
	assign EVT_COUNT = st_ff.cnt;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	a_reset_empty_state: assert property ($rose(RST_N) |-> BUF_EMPTY && !BUF_FULL && !BUF_OVW)
		else $error("status not empty after reset");
	a_flag_clear_empties: assert property (clr_flags && !CAP_VALID |=> BUF_EMPTY && !BUF_FULL && !BUF_OVW)
		else $error("flag clear did not empty buffer");
	a_clear_keeps_banks: assert property (CMD_TRG_WR && !CAP_VALID |-> !mem_if.wr_en)
		else $error("trigger wrote a bank");
	a_first_to_bank6: assert property (CAP_VALID && BUF_EMPTY && !CMD_TRG_WR |->
		mem_if.wr_en && mem_if.wr_addr == 1'b0 ##1 !BUF_EMPTY && !BUF_FULL && !BUF_OVW)
		else $error("first capture misplaced");
	a_cleared_to_bank6: assert property (clr_flags && CAP_VALID |-> mem_if.wr_en && mem_if.wr_addr == 1'b0)
		else $error("capture after clear not in bank 6");
	a_not_empty_irq: assert property ($fell(BUF_EMPTY) |-> IRQ_NOT_EMPTY)
		else $error("no not-empty request");
	a_read_keeps_flags: assert property (RD_REQ && !CAP_VALID && !CMD_TRG_WR |=>
		$stable(BUF_EMPTY) && $stable(BUF_FULL) && $stable(BUF_OVW))
		else $error("read changed flags");
	a_second_to_bank7: assert property (CAP_VALID && !BUF_EMPTY && !BUF_FULL && !CMD_TRG_WR |->
		mem_if.wr_en && mem_if.wr_addr == 1'b1 ##1 BUF_FULL && !BUF_EMPTY && !BUF_OVW)
		else $error("second capture misplaced");
	a_full_irq: assert property ($rose(BUF_FULL) |-> IRQ_FULL)
		else $error("no full request");
	a_overwrite_bank7: assert property (CAP_VALID && BUF_FULL && !CMD_TRG_WR && OVW_MODE == TSBUF_MODE_OVERWRITE |->
		mem_if.wr_en && mem_if.wr_addr == 1'b1 ##1 BUF_OVW && IRQ_OVW && BUF_FULL)
		else $error("overwrite capture wrong");
	a_inhibit_discard: assert property (CAP_VALID && BUF_FULL && !CMD_TRG_WR && OVW_MODE == TSBUF_MODE_INHIBIT |->
		!mem_if.wr_en ##1 BUF_OVW && IRQ_OVW)
		else $error("inhibit capture wrong");
	a_ovw_sticky: assert property (BUF_OVW && !clr_flags |=> BUF_OVW)
		else $error("overwrite flag dropped");
	a_counter_clear: assert property (clr_cnt && !(CAP_VALID && CAP_SRC[0]) |=> EVT_COUNT[0] == 6'h00)
		else $error("counter not cleared");
	a_counter_step: assert property (CAP_VALID && CAP_SRC[0] && !CMD_TRG_WR |=>
		EVT_COUNT[0] == 6'($past(EVT_COUNT[0]) + 6'h01))
		else $error("counter did not step");
	a_counter_step_top: assert property (CAP_VALID && CAP_SRC[NIN-1] && !CMD_TRG_WR |=>
		EVT_COUNT[NIN-1] == 6'($past(EVT_COUNT[NIN-1]) + 6'h01))
		else $error("last counter did not step");
	a_counter_hold: assert property (!CAP_VALID && !clr_cnt |=> $stable(EVT_COUNT))
		else $error("counter moved without capture");
	a_reset_quiet_outputs: assert property ($rose(RST_N) |->
		!IRQ_NOT_EMPTY && !IRQ_FULL && !IRQ_OVW && !RD_VALID && EVT_COUNT == '0)
		else $error("outputs not quiet after reset");
	a_clear_then_capture: assert property (clr_flags && CAP_VALID |=>
		!BUF_EMPTY && !BUF_FULL && !BUF_OVW && IRQ_NOT_EMPTY)
		else $error("capture beside clear misplaced");
	// Interrupt pulses must always have a cause behind them
	a_ne_irq_cause: assert property (IRQ_NOT_EMPTY |->
		!BUF_EMPTY && ($past(BUF_EMPTY) || $past(CMD_TRG_WR)))
		else $error("not-empty request without cause");
	a_full_irq_cause: assert property (IRQ_FULL |-> $rose(BUF_FULL))
		else $error("full request without cause");
	a_ovw_irq_cause: assert property (IRQ_OVW |-> BUF_OVW && BUF_FULL)
		else $error("overwrite request while not full");

	c_fill_full: cover property (BUF_EMPTY ##[1:20] BUF_FULL);
	c_overwrite_seen: cover property (IRQ_OVW && OVW_MODE == TSBUF_MODE_OVERWRITE);
	c_clear_after_full: cover property (BUF_FULL && clr_flags ##1 BUF_EMPTY);
	c_counter_wrap: cover property (EVT_COUNT[0] == 6'h3F ##[1:10] EVT_COUNT[0] == 6'h00);
	// Same-cycle clear and capture is the case most easily broken by a rework
	c_clear_with_capture: cover property (clr_flags && CAP_VALID);
endmodule // tsbuf_top

// >>> test/tsbuf_host_model.sv
// Host-side model that issues captures, command triggers and bank reads
`timescale 1ns/100ps
module tsbuf_host_model #(
	parameter int DW = 64,
	parameter int NIN = 3,
	parameter int TRIG_GAP = 4
) (
	input wire logic clk,                       // Block clock
	output logic cap_valid,                     // Capture strobe
	output logic [DW-1:0] cap_data,             // Time stamp to capture
	output logic [NIN-1:0] cap_src,             // One-hot source input
	output tsbuf_pkg::tsbuf_mode_t ovw_mode,    // Overwrite or inhibit
	output logic [7:0] cmd_cfg,                 // Command configuration value
	output logic cmd_trg_wr,                    // Trigger register write pulse
	output logic rd_req,                        // Bank read pulse
	output logic rd_bank,                       // Bank select
	input wire logic rd_valid,                  // Read answer strobe
	input wire logic [DW-1:0] rd_data           // Read answer data
);
	import tsbuf_pkg::*;
	initial begin
		cap_valid = 1'b0;
		cap_data = '0;
		cap_src = '0;
		ovw_mode = TSBUF_MODE_OVERWRITE;
		cmd_cfg = 8'h00;
		cmd_trg_wr = 1'b0;
		rd_req = 1'b0;
		rd_bank = 1'b0;
	end
	task automatic set_mode(input tsbuf_mode_t m);
		@(negedge clk);
		ovw_mode = m;
	endtask
	// Idle data is the inverse of the last word so a stale value never looks valid
	task automatic capture(input logic [DW-1:0] data, input logic [NIN-1:0] src);
		@(negedge clk);
		cap_valid = 1'b1;
		cap_data = data;
		cap_src = src;
		@(negedge clk);
		cap_valid = 1'b0;
		cap_data = ~data;
		cap_src = '0;
	endtask
	// Gap is far shorter than the real host spacing to keep the run short
	task automatic command(input logic [7:0] cfg);
		@(negedge clk);
		cmd_cfg = cfg;
		cmd_trg_wr = 1'b1;
		@(negedge clk);
		cmd_trg_wr = 1'b0;
		repeat (TRIG_GAP) @(negedge clk);
	endtask
	task automatic capture_and_command(input logic [DW-1:0] data, input logic [NIN-1:0] src, input logic [7:0] cfg);
		@(negedge clk);
		cap_valid = 1'b1;
		cap_data = data;
		cap_src = src;
		cmd_cfg = cfg;
		cmd_trg_wr = 1'b1;
		@(negedge clk);
		cap_valid = 1'b0;
		cap_data = ~data;
		cap_src = '0;
		cmd_trg_wr = 1'b0;
		repeat (TRIG_GAP) @(negedge clk);
	endtask
	task automatic read(input logic bank, output logic [DW-1:0] data, output logic ok);
		@(negedge clk);
		rd_req = 1'b1;
		rd_bank = bank;
		@(negedge clk);
		rd_req = 1'b0;
		rd_bank = ~bank;
		ok = rd_valid;
		data = rd_data;
	endtask
endmodule // tsbuf_host_model

// >>> test/tb_top.sv
// Self-checking testbench for the two-bank time stamp buffer
`timescale 1ns/100ps
module tb_top;
	import tsbuf_pkg::*;
	localparam int DW = 64;
	localparam int NIN = 3;
	logic ref_clk, rst_n, cap_valid, cmd_trg_wr, rd_req, rd_bank, rd_valid;
	logic buf_empty, buf_full, buf_ovw, irq_ne, irq_full, irq_ovw;
	logic [DW-1:0] cap_data, rd_data;
	logic [NIN-1:0] cap_src;
	logic [7:0] cmd_cfg;
	logic [NIN-1:0][5:0] evt_count;
	tsbuf_mode_t ovw_mode;
	int fail_count = 0;
	int checked = 0;
	tsbuf_host_model #(.DW(DW), .NIN(NIN)) host (.clk(ref_clk), .cap_valid(cap_valid), .cap_data(cap_data),
		.cap_src(cap_src), .ovw_mode(ovw_mode), .cmd_cfg(cmd_cfg), .cmd_trg_wr(cmd_trg_wr), .rd_req(rd_req),
		.rd_bank(rd_bank), .rd_valid(rd_valid), .rd_data(rd_data));
	tsbuf_top #(.DW(DW), .NIN(NIN)) uut (.REF_CLK(ref_clk), .RST_N(rst_n), .CAP_VALID(cap_valid),
		.CAP_DATA(cap_data), .CAP_SRC(cap_src), .OVW_MODE(ovw_mode), .CMD_CFG(cmd_cfg), .CMD_TRG_WR(cmd_trg_wr),
		.RD_REQ(rd_req), .RD_BANK(rd_bank), .RD_DATA(rd_data), .RD_VALID(rd_valid), .BUF_EMPTY(buf_empty),
		.BUF_FULL(buf_full), .BUF_OVW(buf_ovw), .IRQ_NOT_EMPTY(irq_ne), .IRQ_FULL(irq_full),
		.IRQ_OVW(irq_ovw), .EVT_COUNT(evt_count));
	// ----------------------------------------
	// Compare helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic st(input logic e, input logic f, input logic o, input logic ine, input logic ifu, input logic io);
		chk("empty flag", DW'(e), DW'(buf_empty));
		chk("full flag", DW'(f), DW'(buf_full));
		chk("overwrite flag", DW'(o), DW'(buf_ovw));
		chk("not empty irq", DW'(ine), DW'(irq_ne));
		chk("full irq", DW'(ifu), DW'(irq_full));
		chk("overwrite irq", DW'(io), DW'(irq_ovw));
	endtask
	task automatic rdchk(input logic bank, input logic [DW-1:0] exp);
		logic [DW-1:0] d;
		logic v;
		host.read(bank, d, v);
		chk("read valid", DW'(1'b1), DW'(v));
		chk("bank data", exp, d);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_overwrite();
		host.set_mode(TSBUF_MODE_OVERWRITE);
		st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("count0", DW'(6'h00), DW'(evt_count[0]));
		host.capture(64'h1111_0000_0000_0001, 3'h1);
		st(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		rdchk(1'b0, 64'h1111_0000_0000_0001);
		st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		host.capture(64'h2222_0000_0000_0002, 3'h1);
		st(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		rdchk(1'b1, 64'h2222_0000_0000_0002);
		st(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		host.capture(64'h3333_0000_0000_0003, 3'h1);
		st(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		host.capture(64'h4444_0000_0000_0004, 3'h1);
		st(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		rdchk(1'b1, 64'h4444_0000_0000_0004);
		rdchk(1'b0, 64'h1111_0000_0000_0001);
		chk("count0", DW'(6'h04), DW'(evt_count[0]));
		$display("test overwrite done");
	endtask
	task automatic t_clear_bits();
		host.command(8'h00);
		st(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		host.command(8'h10);
		st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("count0", DW'(6'h04), DW'(evt_count[0]));
		host.command(8'h80);
		chk("count0", DW'(6'h00), DW'(evt_count[0]));
		rdchk(1'b0, 64'h1111_0000_0000_0001);
		rdchk(1'b1, 64'h4444_0000_0000_0004);
		$display("test clear bits done");
	endtask
	task automatic t_inhibit();
		host.set_mode(TSBUF_MODE_INHIBIT);
		host.capture(64'hAAAA_0000_0000_0005, 3'h4);
		st(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		host.capture(64'hBBBB_0000_0000_0006, 3'h4);
		st(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		host.capture(64'hCCCC_0000_0000_0007, 3'h4);
		st(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		rdchk(1'b0, 64'hAAAA_0000_0000_0005);
		rdchk(1'b1, 64'hBBBB_0000_0000_0006);
		chk("count2", DW'(6'h03), DW'(evt_count[2]));
		host.command(8'h90);
		st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("count2", DW'(6'h00), DW'(evt_count[2]));
		host.capture(64'hDDDD_0000_0000_0008, 3'h4);
		chk("count2", DW'(6'h01), DW'(evt_count[2]));
		rdchk(1'b0, 64'hDDDD_0000_0000_0008);
		host.capture(64'hFFFF_0000_0000_0009, 3'h4);
		host.capture_and_command(64'hEEEE_0000_0000_000A, 3'h4, 8'h90);
		st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("count2", DW'(6'h01), DW'(evt_count[2]));
		rdchk(1'b0, 64'hEEEE_0000_0000_000A);
		rdchk(1'b1, 64'hFFFF_0000_0000_0009);
		$display("test inhibit done");
	endtask
	task automatic t_counter_wrap();
		host.command(8'h80);
		for (int i = 0; i < 63; i++) begin
			host.capture(64'h7777_0000_0000_0000, 3'h1);
		end
		chk("count0", DW'(6'h3F), DW'(evt_count[0]));
		host.capture(64'h7777_0000_0000_0040, 3'h1);
		chk("count0", DW'(6'h00), DW'(evt_count[0]));
		host.capture(64'h8888_0000_0000_0001, 3'h2);
		host.capture(64'h8888_0000_0000_0002, 3'h2);
		chk("count1", DW'(6'h02), DW'(evt_count[1]));
		chk("count2", DW'(6'h00), DW'(evt_count[2]));
		$display("test counter wrap done");
	endtask
	task automatic t_reset_again();
		@(negedge ref_clk);
		rst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("counters", DW'(18'h0), DW'(evt_count));
		chk("read valid", DW'(1'b0), DW'(rd_valid));
		chk("read data", 64'h0, rd_data);
		host.capture(64'h5555_0000_0000_0009, 3'h2);
		st(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		rdchk(1'b0, 64'h5555_0000_0000_0009);
		$display("test reset again done");
	endtask
	// ----------------------------------------
	// Clock, reset, sequence and watchdog
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		rst_n = 1'b0;
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		t_overwrite();
		t_clear_bits();
		t_inhibit();
		t_counter_wrap();
		t_reset_again();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		$display("mismatch watchdog expected finish seen timeout");
		tally_and_finish();
	end
endmodule // tb_top
